// ### hw/regctl_cfg.svh
`ifndef REGCTL_CFG_SVH
`define REGCTL_CFG_SVH
// Register indices of the internal register port
`define REG_IDX_LREG1_CODE 4'h0
`define REG_IDX_LREG2_CODE 4'h1
`define REG_IDX_LREG3_CODE 4'h2
`define REG_IDX_LREG_CTRL 4'h3
`define REG_IDX_BUCK_CTRL 4'h4
`define REG_IDX_STATUS 4'h5
`define REG_IDX_CHAIN_CFG 4'h6
`define REG_COUNT 7
// Control field positions
`define LREG_CTRL_ON_LSB 0
`define LREG_CTRL_SWITCH_MODE 3
`define BUCK_CTRL_ON_LSB 0
`define BUCK_CTRL_ILIM_LSB 2
`define BUCK_ILIM_W 3
// Status field positions
`define STAT_WARN_LSB 0
`define STAT_SHDN_LSB 2
`define STAT_UV_LSB 4
// Reset values
`define LREG_CODE_RESET 6'h18
`define LREG_CTRL_RESET 8'h00
`define BUCK_CTRL_RESET 8'h00
`define CHAIN_CFG_RESET 8'h00
// Setpoint arithmetic, millivolts
`define VOUT_BASE_MV 12'd600
`define VOUT_STEP_MV 12'd50
`define VOUT_MAX_MV 12'd3600
// Overload counting
`define OC_WARN_CYCLES 4'd2
`define OC_SHDN_CYCLES 4'd8
// Soft-start ramp: 1.7 V/ms, one mV step per ramp tick
`define RAMP_UV_PER_MS 1700
`define CLK_KHZ 50000
`define RAMP_TICK_CYCLES ((`CLK_KHZ + `RAMP_UV_PER_MS - 1) / `RAMP_UV_PER_MS)
`endif

// ### hw/regctl_pkg.sv
package regctl_pkg;
	typedef logic [5:0] vcode_t;
	typedef logic [11:0] millivolt_t;
	typedef enum logic [1:0] {
		LREG_OFF = 2'b00,
		LREG_RAMP = 2'b01,
		LREG_ON = 2'b11,
		LREG_FAULT = 2'b10
	} lreg_state_t;
endpackage

// ### hw/buck_overload.sv
`timescale 1ns/1ns
`include "regctl_cfg.svh"
module buck_overload
	import regctl_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic enable,
	input wire logic cycle_start,
	input wire logic cycle_end,
	input wire logic peak_at_limit,
	input wire logic peak_at_125,
	output logic power_fet_on,
	output logic warn_pulse,
	output logic shutdown
);
	logic [3:0] run;
	logic [3:0] next_run;
	logic seen125;
	logic next_seen125;
	logic fet;
	logic next_fet;
	logic next_shutdown;
	logic next_warn;

	always_comb begin
		next_run = run;
		next_seen125 = seen125 | peak_at_125;
		next_fet = fet;
		next_shutdown = shutdown;
		next_warn = 1'b0;
		if (cycle_start)
			next_fet = 1'b1;
		if (peak_at_limit)
			next_fet = 1'b0;
		if (cycle_end) begin
			next_seen125 = 1'b0;
			if (seen125 | peak_at_125) begin
				next_run = (run == 4'hf) ? run : run + 4'd1;
				if (run + 4'd1 == `OC_WARN_CYCLES)
					next_warn = 1'b1;
				if (run + 4'd1 == `OC_SHDN_CYCLES)
					next_shutdown = 1'b1;
			end else begin
				next_run = 4'd0;
			end
		end
		if (!enable) begin
			next_run = 4'd0;
			next_seen125 = 1'b0;
			next_shutdown = 1'b0;
			next_fet = 1'b0;
		end
		if (next_shutdown)
			next_fet = 1'b0;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			run <= 4'd0;
			seen125 <= 1'b0;
			fet <= 1'b0;
			shutdown <= 1'b0;
			warn_pulse <= 1'b0;
		end else begin
			run <= next_run;
			seen125 <= next_seen125;
			fet <= next_fet;
			shutdown <= next_shutdown;
			warn_pulse <= next_warn;
		end
	end

	// Cut the FET in the same cycle the limit trips
	assign power_fet_on = fet & ~peak_at_limit & ~shutdown;

	chk_fet_cut_limit: assert property (@(posedge clk) disable iff (!reset_n)
		peak_at_limit |-> !power_fet_on) else $error("FET on at limit");
	chk_fet_stays_off: assert property (@(posedge clk) disable iff (!reset_n)
		peak_at_limit && !cycle_start |=> !power_fet_on || cycle_start)
		else $error("FET back on within cycle");
	chk_warn_at_two: assert property (@(posedge clk) disable iff (!reset_n)
		enable && cycle_end && (peak_at_125 || seen125) && run == 4'd1
		|=> warn_pulse)
		else $error("No warning after two cycles");
	chk_shdn_at_eight: assert property (@(posedge clk) disable iff (!reset_n)
		enable && cycle_end && (peak_at_125 || seen125) && run == 4'd7
		|=> shutdown)
		else $error("No shutdown after eight cycles");
	chk_count_clear: assert property (@(posedge clk) disable iff (!reset_n)
		enable && cycle_end && !peak_at_125 && !seen125 |=> run == 4'd0)
		else $error("Count not cleared");
	chk_disable_clear: assert property (@(posedge clk) disable iff (!reset_n)
		!enable |=> run == 4'd0 && !shutdown)
		else $error("Disable did not clear");
	cov_warn: cover property (@(posedge clk) disable iff (!reset_n) warn_pulse);
	cov_shdn: cover property (@(posedge clk) disable iff (!reset_n)
		$rose(shutdown));
endmodule

// ### hw/regulator_protection_and_ldo_control.sv
`timescale 1ns/1ns
`include "regctl_cfg.svh"
// Summary of operation
// - A converter's power FET goes off for the rest of a cycle at the limit.
// - The converter's peak limit comes from a host-written select field.
// - Two cycles in a row at 125% flag a warning and pull the irq low.
// - Eight cycles in a row at 125% shut that converter down.
// - A sustained overload sagging the output shuts down via undervoltage.
// - Each linear regulator ramps at 1.7 V/ms on enable and fault recovery.
// - The target is 0.6 V plus code times 50 mV from a six-bit code.
// - Targets span 0.6 V to 3.6 V and codes above saturate at 3.6 V.
// - Each linear regulator has just one setpoint register.
// - Each linear regulator follows its host-written on bit.
// - A disabled linear regulator engages its output discharge path.
// - Disabling a trigger regulator propagates per factory configuration.
// - The third linear regulator can act as a plain load switch.
// - Its mode bit selects regulating at 0 and load switch at 1.
// - A fault interrupt from linear regulator 1 or 2 (not 3) stays latched until status read and fault gone.
module regulator_protection_and_ldo_control
	import regctl_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [3:0] reg_index,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [1:0] buck_cycle_start,
	input wire logic [1:0] buck_cycle_end,
	input wire logic [1:0] buck_peak_at_limit,
	input wire logic [1:0] buck_peak_at_125,
	input wire logic [1:0] buck_output_uv,
	input wire logic [2:0] linear_reg_fault,
	output logic [1:0] buck_power_fet_on,
	output logic [1:0] buck_enabled,
	output logic [5:0] buck_current_limit_select,
	output logic [35:0] linear_reg_target_mv,
	output logic [2:0] linear_reg_pass_on,
	output logic [2:0] linear_reg_discharge,
	output logic linear_reg3_switch_mode,
	output logic interrupt_request_n
);
	function automatic millivolt_t code_to_mv(input vcode_t code);
		millivolt_t mv;
		mv = `VOUT_BASE_MV + 12'(code) * `VOUT_STEP_MV;
		return (mv > `VOUT_MAX_MV) ? `VOUT_MAX_MV : mv;
	endfunction

	localparam int RAMP_TICKS = `RAMP_TICK_CYCLES;

	// Asynchronous flags except the peak limit comparator pass two flops first
	logic [10:0] raw_sync1;
	logic [10:0] raw_sync2;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			raw_sync1 <= '0;
			raw_sync2 <= '0;
		end else begin
			raw_sync1 <= {linear_reg_fault, buck_output_uv, buck_peak_at_125,
				buck_cycle_end, buck_cycle_start};
			raw_sync2 <= raw_sync1;
		end
	end
	logic [1:0] s_start;
	logic [1:0] s_end;
	logic [1:0] s_125;
	logic [1:0] s_uv;
	logic [2:0] s_lfault;
	assign s_start = raw_sync2[1:0];
	assign s_end = raw_sync2[3:2];
	assign s_125 = raw_sync2[5:4];
	assign s_uv = raw_sync2[7:6];
	assign s_lfault = raw_sync2[10:8];

	// One setpoint per linear regulator, no alternate
	vcode_t lreg_code [3];
	vcode_t next_lreg_code [3];
	logic [7:0] lreg_ctrl;
	logic [7:0] next_lreg_ctrl;
	logic [7:0] buck_ctrl;
	logic [7:0] next_buck_ctrl;
	logic [7:0] chain_cfg;
	logic [7:0] next_chain_cfg;
	logic [5:0] status;
	logic [5:0] next_status;
	logic [5:0] read_snap;
	logic [5:0] next_read_snap;

	logic [1:0] warn_pulse;
	logic [1:0] oc_shutdown;
	logic [5:0] live_status;

	always_comb begin
		for (int i = 0; i < 3; i++)
			next_lreg_code[i] = lreg_code[i];
		next_lreg_ctrl = lreg_ctrl;
		next_buck_ctrl = buck_ctrl;
		next_chain_cfg = chain_cfg;
		if (reg_write) begin
			unique case (reg_index)
				`REG_IDX_LREG1_CODE: next_lreg_code[0] = reg_wdata[5:0];
				`REG_IDX_LREG2_CODE: next_lreg_code[1] = reg_wdata[5:0];
				`REG_IDX_LREG3_CODE: next_lreg_code[2] = reg_wdata[5:0];
				`REG_IDX_LREG_CTRL: next_lreg_ctrl = reg_wdata;
				`REG_IDX_BUCK_CTRL: next_buck_ctrl = reg_wdata;
				`REG_IDX_CHAIN_CFG: next_chain_cfg = reg_wdata;
				default: ;
			endcase
		end
		// Converter shutdown drops its on bit so software sees it
		for (int i = 0; i < 2; i++)
			if (oc_shutdown[i] || s_uv[i])
				next_buck_ctrl[`BUCK_CTRL_ON_LSB + i] = 1'b0;
		// Factory chain: bit i makes linear reg i follow reg i-1 off
		for (int i = 1; i < 3; i++)
			if (chain_cfg[i] && !next_lreg_ctrl[`LREG_CTRL_ON_LSB + i - 1])
				next_lreg_ctrl[`LREG_CTRL_ON_LSB + i] = 1'b0;
	end

	assign live_status = {1'b0, s_lfault[0] | s_lfault[1], oc_shutdown,
		warn_pulse};

	always_comb begin
		next_read_snap = read_snap;
		next_status = status | live_status;
		if (reg_read && reg_index == `REG_IDX_STATUS)
			next_read_snap = status;
		else if (reg_write)
			next_read_snap = '0;
		// Clear only bits read and no longer active; set wins
		if (reg_read && reg_index == `REG_IDX_STATUS)
			next_status = (status & ~(status & ~live_status)) | live_status;
		next_status = next_status & {6{1'b1}};
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 3; i++)
				lreg_code[i] <= `LREG_CODE_RESET;
			lreg_ctrl <= `LREG_CTRL_RESET;
			buck_ctrl <= `BUCK_CTRL_RESET;
			chain_cfg <= `CHAIN_CFG_RESET;
			status <= '0;
			read_snap <= '0;
		end else begin
			for (int i = 0; i < 3; i++)
				lreg_code[i] <= next_lreg_code[i];
			lreg_ctrl <= next_lreg_ctrl;
			buck_ctrl <= next_buck_ctrl;
			chain_cfg <= next_chain_cfg;
			status <= next_status;
			read_snap <= next_read_snap;
		end
	end

	always_comb begin
		unique case (reg_index)
			`REG_IDX_LREG1_CODE: reg_rdata = {2'b00, lreg_code[0]};
			`REG_IDX_LREG2_CODE: reg_rdata = {2'b00, lreg_code[1]};
			`REG_IDX_LREG3_CODE: reg_rdata = {2'b00, lreg_code[2]};
			`REG_IDX_LREG_CTRL: reg_rdata = lreg_ctrl;
			`REG_IDX_BUCK_CTRL: reg_rdata = buck_ctrl;
			`REG_IDX_STATUS: reg_rdata = {2'b00, status};
			`REG_IDX_CHAIN_CFG: reg_rdata = chain_cfg;
			default: reg_rdata = 8'h00;
		endcase
	end

	for (genvar b = 0; b < 2; b++) begin : g_buck
		assign buck_enabled[b] = buck_ctrl[`BUCK_CTRL_ON_LSB + b];
		assign buck_current_limit_select[b*3 +: 3] =
			buck_ctrl[`BUCK_CTRL_ILIM_LSB + b*3 +: 3];
		buck_overload u_ovl (
			.clk(clk),
			.reset_n(reset_n),
			.enable(buck_enabled[b]),
			.cycle_start(s_start[b]),
			.cycle_end(s_end[b]),
			.peak_at_limit(buck_peak_at_limit[b]),
			.peak_at_125(s_125[b]),
			.power_fet_on(buck_power_fet_on[b]),
			.warn_pulse(warn_pulse[b]),
			.shutdown(oc_shutdown[b])
		);
	end

	// Linear regulators: enable follows on bit, ramp 1 mV per tick
	lreg_state_t lstate [3];
	lreg_state_t next_lstate [3];
	millivolt_t ramp_mv [3];
	millivolt_t next_ramp_mv [3];
	logic [5:0] tick_cnt;
	logic [5:0] next_tick_cnt;
	logic tick;

	assign tick = (tick_cnt == 6'(RAMP_TICKS - 1));
	always_comb begin
		next_tick_cnt = tick ? 6'd0 : tick_cnt + 6'd1;
		for (int i = 0; i < 3; i++) begin
			next_lstate[i] = lstate[i];
			next_ramp_mv[i] = ramp_mv[i];
			unique case (lstate[i])
				LREG_OFF: begin
					next_ramp_mv[i] = '0;
					if (lreg_ctrl[`LREG_CTRL_ON_LSB + i])
						next_lstate[i] = LREG_RAMP;
				end
				LREG_RAMP: begin
					if (tick)
						next_ramp_mv[i] = ramp_mv[i] + 12'd1;
					if (ramp_mv[i] >= code_to_mv(lreg_code[i]))
						next_lstate[i] = LREG_ON;
				end
				LREG_ON: next_ramp_mv[i] = code_to_mv(lreg_code[i]);
				LREG_FAULT: begin
					next_ramp_mv[i] = '0;
					if (!s_lfault[i])
						next_lstate[i] = LREG_RAMP;
				end
			endcase
			if (s_lfault[i] && lstate[i] != LREG_OFF)
				next_lstate[i] = LREG_FAULT;
			if (!lreg_ctrl[`LREG_CTRL_ON_LSB + i])
				next_lstate[i] = LREG_OFF;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_cnt <= '0;
			for (int i = 0; i < 3; i++) begin
				lstate[i] <= LREG_OFF;
				ramp_mv[i] <= '0;
			end
		end else begin
			tick_cnt <= next_tick_cnt;
			for (int i = 0; i < 3; i++) begin
				lstate[i] <= next_lstate[i];
				ramp_mv[i] <= next_ramp_mv[i];
			end
		end
	end

	for (genvar l = 0; l < 3; l++) begin : g_lreg
		assign linear_reg_target_mv[l*12 +: 12] = ramp_mv[l];
		assign linear_reg_pass_on[l] = lstate[l] == LREG_RAMP ||
			lstate[l] == LREG_ON;
		assign linear_reg_discharge[l] = lstate[l] == LREG_OFF;
	end
	// Load switch just closes the pass device; target ignored
	assign linear_reg3_switch_mode = lreg_ctrl[`LREG_CTRL_SWITCH_MODE];

	assign interrupt_request_n = ~(|status);

	chk_discharge_off: assert property (@(posedge clk) disable iff (!reset_n)
		!lreg_ctrl[0] |=> linear_reg_discharge[0] && !linear_reg_pass_on[0])
		else $error("Discharge not engaged");
	chk_irq_on_warn: assert property (@(posedge clk) disable iff (!reset_n)
		warn_pulse[0] |=> !interrupt_request_n)
		else $error("Warning did not raise irq");
	chk_irq_latched: assert property (@(posedge clk) disable iff (!reset_n)
		!interrupt_request_n && !(reg_read && reg_index == `REG_IDX_STATUS)
		|=> !interrupt_request_n) else $error("Irq dropped without read");
	chk_target_sat: assert property (@(posedge clk) disable iff (!reset_n)
		lstate[0] == LREG_ON |=> ramp_mv[0] <= `VOUT_MAX_MV)
		else $error("Target above 3.6 V");
	chk_ramp_rate: assert property (@(posedge clk) disable iff (!reset_n)
		lstate[1] == LREG_RAMP && $past(lstate[1]) == LREG_RAMP
		|-> ramp_mv[1] - $past(ramp_mv[1]) <= 12'd1)
		else $error("Ramp too fast");
	chk_ilim_field: assert property (@(posedge clk) disable iff (!reset_n)
		reg_write && reg_index == `REG_IDX_BUCK_CTRL |=>
		buck_current_limit_select[2:0] == $past(reg_wdata[4:2]))
		else $error("Limit select not taken");
	cov_lreg_on: cover property (@(posedge clk) disable iff (!reset_n)
		lstate[0] == LREG_ON);
	cov_status_read: cover property (@(posedge clk) disable iff (!reset_n)
		reg_read && reg_index == `REG_IDX_STATUS && |status);
	cov_switch_mode: cover property (@(posedge clk) disable iff (!reset_n)
		linear_reg3_switch_mode && linear_reg_pass_on[2]);
endmodule

// ### bench/buck_stage_model.sv
`timescale 1ns/1ns
module buck_stage_model (
	input wire logic clk,
	input wire logic [1:0] over_125,
	input wire logic [1:0] over_limit,
	output logic [1:0] cycle_start,
	output logic [1:0] cycle_end,
	output logic [1:0] peak_at_limit,
	output logic [1:0] peak_at_125
);
	// Ten-clock switching cycle, both converters in step
	logic [3:0] phase = 4'h0;
	initial begin
		cycle_start = 2'b00;
		cycle_end = 2'b00;
		peak_at_limit = 2'b00;
		peak_at_125 = 2'b00;
	end
	always @(posedge clk) begin
		phase <= (phase == 4'h9) ? 4'h0 : phase + 4'h1;
		cycle_start <= {2{phase == 4'h9}};
		cycle_end <= {2{phase == 4'h8}};
		// Trips only mid-cycle, so a cycle never straddles two verdicts
		peak_at_limit <= over_limit & {2{phase > 4'h3 && phase < 4'h8}};
		peak_at_125 <= over_125 & {2{phase > 4'h2 && phase < 4'h7}};
	end
endmodule

// ### bench/regulator_protection_and_ldo_control_tb.sv
`timescale 1ns/1ns
`include "regctl_cfg.svh"
module regulator_protection_and_ldo_control_tb;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [3:0] reg_index = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic [1:0] over_125 = 2'b00;
	logic [1:0] over_limit = 2'b00;
	logic [1:0] output_uv = 2'b00;
	logic [2:0] lfault = 3'b000;
	logic [1:0] cyc_start, cyc_end, at_limit, at_125, fet_on, enabled;
	logic [5:0] ilim_sel;
	logic [35:0] target_mv;
	logic [2:0] pass_on, discharge;
	logic switch_mode, irq_n;
	int num_errors = 0;
	int n_tests = 0;

	initial forever #10 clk = ~clk;

	buck_stage_model i_buck_stage_model (
		.clk(clk), .over_125(over_125), .over_limit(over_limit),
		.cycle_start(cyc_start), .cycle_end(cyc_end),
		.peak_at_limit(at_limit), .peak_at_125(at_125)
	);

	regulator_protection_and_ldo_control i_regulator_protection_and_ldo_control (
		.clk(clk), .reset_n(reset_n), .reg_write(reg_write),
		.reg_read(reg_read), .reg_index(reg_index), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .buck_cycle_start(cyc_start),
		.buck_cycle_end(cyc_end), .buck_peak_at_limit(at_limit),
		.buck_peak_at_125(at_125), .buck_output_uv(output_uv),
		.linear_reg_fault(lfault), .buck_power_fet_on(fet_on),
		.buck_enabled(enabled), .buck_current_limit_select(ilim_sel),
		.linear_reg_target_mv(target_mv), .linear_reg_pass_on(pass_on),
		.linear_reg_discharge(discharge),
		.linear_reg3_switch_mode(switch_mode),
		.interrupt_request_n(irq_n)
	);

	task automatic chk(input string what, input logic [35:0] exp,
		input logic [35:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic ticks(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wr(input logic [3:0] idx, input logic [7:0] data);
		@(posedge clk);
		reg_index <= idx;
		reg_wdata <= data;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask

	// Read data is combinational, so it is taken at the strobe's edge
	task automatic rd(input logic [3:0] idx, output logic [7:0] data);
		@(posedge clk);
		reg_index <= idx;
		reg_read <= 1'b1;
		@(posedge clk);
		data = reg_rdata;
		reg_read <= 1'b0;
	endtask

	// Converter 0 overloads for n whole cycles after one clean cycle
	task automatic burst(input logic val, input int n);
		do @(posedge clk); while (cyc_end[0] !== 1'b1);
		over_125 <= {1'b0, val};
		repeat (n) begin
			do @(posedge clk); while (cyc_end[0] !== 1'b1);
		end
		over_125 <= 2'b00;
	endtask

	task automatic t_reset_regs();
		logic [7:0] d;
		for (int i = 0; i < 3; i++) begin
			rd(i[3:0], d);
			chk("setpoint code", {30'd0, `LREG_CODE_RESET}, {28'd0, d});
		end
		rd(4'hf, d);
		chk("unmapped read", 36'h0, {28'd0, d});
		chk("discharge at reset", 36'h7, {33'd0, discharge});
		chk("irq at reset", 36'h1, {35'd0, irq_n});
		wr(`REG_IDX_LREG3_CODE, 8'h3f);
		rd(`REG_IDX_LREG3_CODE, d);
		chk("top code", 36'h3f, {28'd0, d});
	endtask

	task automatic t_ldo();
		logic [11:0] v;
		int n;
		wr(`REG_IDX_LREG2_CODE, 8'h00);
		wr(`REG_IDX_LREG_CTRL, 8'h02);
		ticks(2);
		chk("pass on", 36'h2, {33'd0, pass_on});
		chk("discharge released", 36'h5, {33'd0, discharge});
		// 3000 cycles at 30 per millivolt
		ticks(3000);
		v = target_mv[23:12];
		chk("ramp rate", 36'h1, {35'd0, v > 12'd96 && v < 12'd103});
		for (n = 0; n < 20000 && target_mv[23:12] !== 12'd600; n++)
			@(posedge clk);
		ticks(60);
		chk("target", {24'd0, `VOUT_BASE_MV}, {24'd0, target_mv[23:12]});
		wr(`REG_IDX_LREG_CTRL, 8'h08);
		ticks(2);
		chk("discharge on", 36'h7, {33'd0, discharge});
		chk("pass off", 36'h0, {33'd0, pass_on});
		chk("switch mode", 36'h1, {35'd0, switch_mode});
		wr(`REG_IDX_LREG_CTRL, 8'h00);
		ticks(2);
		chk("regulate mode", 36'h0, {35'd0, switch_mode});
	endtask

	task automatic t_overload();
		logic [7:0] d;
		wr(`REG_IDX_BUCK_CTRL, 8'h57);
		ticks(1);
		chk("limit select", 36'h15, {30'd0, ilim_sel});
		chk("converters on", 36'h3, {34'd0, enabled});
		burst(1'b1, 1);
		ticks(12);
		chk("single cycle irq", 36'h1, {35'd0, irq_n});
		burst(1'b1, 2);
		ticks(12);
		chk("warning irq", 36'h0, {35'd0, irq_n});
		rd(`REG_IDX_STATUS, d);
		ticks(2);
		chk("irq released", 36'h1, {35'd0, irq_n});
		burst(1'b1, 7);
		burst(1'b1, 7);
		ticks(12);
		chk("count cleared", 36'h1, {35'd0, enabled[0]});
		burst(1'b1, 8);
		ticks(12);
		chk("overload shutdown", 36'h0, {35'd0, enabled[0]});
		chk("other converter", 36'h1, {35'd0, enabled[1]});
	endtask

	task automatic t_limit();
		over_limit <= 2'b10;
		do @(posedge clk); while (at_limit[1] !== 1'b1);
		#1 chk("fet cut", 36'h0, {35'd0, fet_on[1]});
		do @(posedge clk); while (cyc_end[1] !== 1'b1);
		#1 chk("fet stays off", 36'h0, {35'd0, fet_on[1]});
		over_limit <= 2'b00;
		output_uv <= 2'b10;
		ticks(6);
		chk("uv shutdown", 36'h0, {35'd0, enabled[1]});
		output_uv <= 2'b00;
	endtask

	// Chained turn-off, then a linear fault and its recovery
	task automatic t_chain_fault();
		logic [7:0] d;
		rd(`REG_IDX_STATUS, d);
		ticks(2);
		chk("irq after clear", 36'h1, {35'd0, irq_n});
		wr(`REG_IDX_CHAIN_CFG, 8'h04);
		wr(`REG_IDX_LREG_CTRL, 8'h06);
		ticks(2);
		chk("chain both on", 36'h6, {33'd0, pass_on});
		wr(`REG_IDX_LREG_CTRL, 8'h04);
		ticks(2);
		chk("chain follower off", 36'h0, {33'd0, pass_on});
		rd(`REG_IDX_LREG_CTRL, d);
		chk("chain ctrl", 36'h0, {28'd0, d});
		wr(`REG_IDX_CHAIN_CFG, 8'h00);
		wr(`REG_IDX_LREG_CTRL, 8'h01);
		ticks(2);
		lfault <= 3'b001;
		ticks(4);
		chk("fault stops pass", 36'h0, {35'd0, pass_on[0]});
		chk("fault irq", 36'h0, {35'd0, irq_n});
		lfault <= 3'b000;
		ticks(4);
		chk("ramp restart", 36'h1, {35'd0, pass_on[0]});
		chk("ramp from zero", 36'h1,
			{35'd0, target_mv[11:0] < 12'd2});
		chk("irq held", 36'h0, {35'd0, irq_n});
		rd(`REG_IDX_STATUS, d);
		chk("fault status", 36'h10, {28'd0, d});
		ticks(2);
		chk("irq cleared", 36'h1, {35'd0, irq_n});
	endtask

	task automatic close_out();
		if (num_errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		ticks(5);
		reset_n <= 1'b1;
		t_reset_regs();
		t_ldo();
		t_overload();
		t_limit();
		t_chain_fault();
		close_out();
	end

	// Ramp to 600 mV takes about 18000 cycles; the rest is short
	initial begin
		ticks(40000);
		num_errors++;
		close_out();
	end
endmodule
